/* verilog/pbsp_pkg.sv */
// Package of constants and carrier types for the burst SRAM port
// What this block does and what it expects of the other party
// R1: Output enable low drives data pins
// R2: Output enable high releases pins, accepts write data
// R3: First read after deselect keeps pins released
// R4: Sampled advance steps burst address
// R5: Processor strobe latches address, loads counter
// R6: Controller strobe latches address, preloads counter
// R7: Both strobes: processor strobe wins
// R8: Processor strobe ignored while first enable high
// R9: Sleep input idles device, keeps contents
// R10: Write data captured on rising edge
// R11: Read data one clock after address
// R12: Strap low selects linear order
// R13: Strap high selects interleaved order
// R14: Other party holds strap static
// R15: Selected only with enables low, high, low
// R16: Global write all bytes, else gated lanes
// R17: Interleaved: start xor beat count
// R18: Linear: increment modulo four
// R19: Registered deselect flag masks first read
// R20: Other party idles across sleep
package pbsp_pkg;
    localparam int PBSP_AW = 16;
    localparam int PBSP_DW = 32;
    localparam int PBSP_LANES = 4;
    localparam int PBSP_DEPTH = 65536;
    localparam int PBSP_SYNC_STAGES = 3;
    localparam logic [1:0] PBSP_BEAT_RESET = 2'h0;
    localparam logic [15:0] PBSP_ADDR_RESET = 16'h0000;
    localparam logic [31:0] PBSP_DATA_RESET = 32'h00000000;
    localparam logic [2:0] PBSP_SYNC_RESET = 3'h0;

    typedef enum logic [1:0] {
        PBSP_IDLE = 2'b00,
        PBSP_READ = 2'b01,
        PBSP_WRITE_PEND = 2'b10
    } pbsp_mode_t;

    typedef struct packed {
        logic chip_sel_first_n;
        logic chip_sel_second;
        logic chip_sel_third_n;
        logic processor_addr_strobe_n;
        logic controller_addr_strobe_n;
        logic burst_advance_n;
        logic global_write_n;
        logic byte_write_gate_n;
        logic [3:0] byte_lane_select_n;
    } pbsp_ctrl_t;
endpackage : pbsp_pkg

/* verilog/pbsp_sync.sv */
// Three-stage synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pbsp_sync (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic async_in,
    output logic sync_out
);
    import pbsp_pkg::*;
    typedef struct packed {
        logic [2:0] stage;
        logic level;
    } pbsp_sync_state_t;
    pbsp_sync_state_t state;
    pbsp_sync_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.stage = {state.stage[1:0], async_in};
        if (state.stage[1] == state.stage[2]) begin
            next_state.level = state.stage[2];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign sync_out = state.level;
endmodule // pbsp_sync
`default_nettype wire

/* verilog/pbsp_port.sv */
// Pipelined burst SRAM port with storage core
`timescale 1ns/100ps
`default_nettype none
module pbsp_port (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire pbsp_pkg::pbsp_ctrl_t ctrl,
    input wire logic [15:0] addr,
    input wire logic [31:0] dq_in,
    output logic [31:0] dq_out,
    output logic dq_oe,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic burst_order_strap,
    output logic sleeping
);
    import pbsp_pkg::*;

    typedef struct packed {
        pbsp_mode_t mode;
        logic [15:0] base_addr;
        logic [1:0] start_low;
        logic [1:0] beat;
        logic was_deselected;
        logic first_read;
        logic [31:0] read_data;
        logic [31:0] write_data;
        logic interleaved;
        logic strap_taken;
    } pbsp_state_t;

    pbsp_state_t state;
    pbsp_state_t next_state;
    logic [31:0] mem [0:PBSP_DEPTH-1];
    logic sleep_sync;
    logic selected;
    logic proc_go;
    logic ctrl_go;
    logic write_req;
    logic [3:0] lane_we;
    logic [1:0] cur_low;
    logic [15:0] cur_addr;
    logic [1:0] next_low;
    logic [15:0] next_addr;
    logic do_write;
    logic [15:0] write_addr;

    pbsp_sync u_sleep_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .async_in(sleep_request),
        .sync_out(sleep_sync)
    );

    assign selected = !ctrl.chip_sel_first_n && ctrl.chip_sel_second
        && !ctrl.chip_sel_third_n; // see R15
    assign proc_go = !sleep_sync && !ctrl.processor_addr_strobe_n
        && !ctrl.chip_sel_first_n; // see R8
    assign ctrl_go = !sleep_sync && !proc_go
        && !ctrl.controller_addr_strobe_n; // see R7
    assign write_req = !ctrl.global_write_n
        || (!ctrl.byte_write_gate_n && !(&ctrl.byte_lane_select_n));
    assign lane_we = !ctrl.global_write_n ? 4'hf
        : (ctrl.byte_write_gate_n ? 4'h0 : ~ctrl.byte_lane_select_n); // see R16

    // Burst address generation
    always_comb begin
        if (state.interleaved) begin
            cur_low = state.start_low ^ state.beat; // see R17
        end else begin
            cur_low = state.start_low + state.beat; // see R18
        end
        cur_addr = {state.base_addr[15:2], cur_low};
        write_addr = ((proc_go || ctrl_go) && selected) ? addr : cur_addr;
    end

    always_comb begin
        next_state = state;
        next_low = cur_low;
        next_addr = cur_addr;
        do_write = 1'b0;
        if (!state.strap_taken) begin
            next_state.interleaved = burst_order_strap; // see R12 R13
            next_state.strap_taken = 1'b1;
        end
        next_state.first_read = 1'b0;
        if ((proc_go || ctrl_go) && selected) begin
            next_state.base_addr = addr; // see R5 R6
            next_state.start_low = addr[1:0];
            next_state.beat = PBSP_BEAT_RESET;
            next_addr = addr;
            next_state.first_read = state.was_deselected; // see R3 R19
            next_state.was_deselected = 1'b0;
            if (ctrl_go && write_req) begin
                do_write = 1'b1;
                next_state.mode = PBSP_IDLE;
            end else if (proc_go) begin
                next_state.mode = PBSP_WRITE_PEND;
            end else begin
                next_state.mode = PBSP_READ;
            end
        end else if (proc_go || ctrl_go) begin
            next_state.was_deselected = 1'b1;
            next_state.mode = PBSP_IDLE;
        end else if (!sleep_sync && state.mode != PBSP_IDLE) begin
            if (write_req) begin
                do_write = 1'b1;
                next_state.mode = PBSP_IDLE;
            end else begin
                next_state.mode = PBSP_READ;
            end
            if (!ctrl.burst_advance_n) begin
                next_state.beat = state.beat + 2'h1; // see R4
                next_low = state.interleaved ? (state.start_low ^ next_state.beat)
                    : (state.start_low + next_state.beat);
                next_addr = {state.base_addr[15:2], next_low};
            end
        end
        next_state.write_data = dq_in; // see R10
        next_state.read_data = mem[next_addr]; // see R11
    end

    always_ff @(posedge core_clk) begin
        if (clk_en && !sleep_sync && reset_n) begin
            for (int i = 0; i < PBSP_LANES; i++) begin
                if (do_write && lane_we[i]) begin
                    mem[write_addr][i*8 +: 8] <= dq_in[i*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '{mode: PBSP_IDLE, base_addr: PBSP_ADDR_RESET,
                start_low: PBSP_BEAT_RESET, beat: PBSP_BEAT_RESET,
                was_deselected: 1'b1, first_read: 1'b0,
                read_data: PBSP_DATA_RESET, write_data: PBSP_DATA_RESET,
                interleaved: 1'b1, strap_taken: 1'b0};
        end else if (clk_en && !sleep_sync) begin // see R9
            state <= next_state;
        end else if (clk_en) begin
            state.mode <= PBSP_IDLE;
        end
    end

    assign dq_out = state.read_data;
    assign dq_oe = !output_enable_n && state.mode != PBSP_IDLE
        && !state.first_read; // see R1 R2 R3
    assign sleeping = sleep_sync;

    first_read_hiz_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state.first_read |-> !dq_oe) else $error("driving on first read"); // see R3
    oe_release_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        output_enable_n |-> !dq_oe) else $error("driving with enable high"); // see R2
    burst_step_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && !sleep_sync && state.mode != PBSP_IDLE && !proc_go && !ctrl_go
        && !ctrl.burst_advance_n |=> state.beat == $past(state.beat) + 2'h1)
        else $error("burst did not step"); // see R4
    strobe_load_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && proc_go && selected |=> state.base_addr == $past(addr))
        else $error("address not latched"); // see R5
    sleep_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        sleep_sync |=> state.base_addr == $past(state.base_addr))
        else $error("state moved in sleep"); // see R9
    strobe_priority_a: assert property (@(posedge core_clk) disable iff (!reset_n) // see R7
        clk_en && !sleep_sync && selected && !ctrl.processor_addr_strobe_n
        && !ctrl.controller_addr_strobe_n |=> state.mode == PBSP_WRITE_PEND)
        else $error("controller strobe not overridden");
    write_capture_a: assert property (@(posedge core_clk) disable iff (!reset_n) // see R10
        clk_en && !sleep_sync |=> state.write_data == $past(dq_in))
        else $error("write data not captured");
    proc_ignore_a: assert property (@(posedge core_clk) disable iff (!reset_n) // see R8
        clk_en && !sleep_sync && ctrl.chip_sel_first_n && !ctrl.processor_addr_strobe_n
        && ctrl.controller_addr_strobe_n |=> state.base_addr == $past(state.base_addr))
        else $error("processor strobe taken while disabled");
    deselect_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n) // see R19
        clk_en && !sleep_sync && (proc_go || ctrl_go) && !selected
        |=> state.was_deselected)
        else $error("deselect not recorded");
    burst_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n) // see R4
        clk_en && !sleep_sync && state.mode != PBSP_IDLE && !proc_go && !ctrl_go
        && ctrl.burst_advance_n |=> state.beat == $past(state.beat))
        else $error("burst stepped without advance");
    strap_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n) // see R12 R13
        state.strap_taken |=> state.interleaved == $past(state.interleaved))
        else $error("burst order changed");
endmodule // pbsp_port
`default_nettype wire

/* dv/pbsp_host_model.sv */
// Host-side model of the shared data wires
`timescale 1ns/100ps
`default_nettype none
module pbsp_host_model (
    input wire logic core_clk,
    input wire logic [31:0] dq_out,
    input wire logic dq_oe,
    input wire logic host_drive,
    input wire logic [31:0] host_data,
    output logic [31:0] dq_wire
);
    logic [31:0] last;
    initial last = 32'h0;
    always @(posedge core_clk) begin
        last <= dq_wire;
    end
    // Released wires show a changing pattern
    always_comb begin
        if (dq_oe) begin
            dq_wire = dq_out;
        end else if (host_drive) begin
            dq_wire = host_data;
        end else begin
            dq_wire = ~last;
        end
    end
endmodule // pbsp_host_model
`default_nettype wire

/* dv/test_pipelined_burst_sram_port.sv */
// Self-checking bench for the burst SRAM port
`timescale 1ns/100ps
`default_nettype none
module test_pipelined_burst_sram_port;
    import pbsp_pkg::*;
    localparam logic [4:0] IDLE = 5'h1f;
    localparam logic [4:0] CW = 5'h15;
    localparam logic [4:0] CBW = 5'h16;
    localparam logic [4:0] PR = 5'h0f;
    localparam logic [4:0] STEP = 5'h1b;
    localparam logic [4:0] CR = 5'h17;
    localparam logic [4:0] BOTH = 5'h05;
    logic core_clk, reset_n, oe_n, strap, host_drive, dq_oe, sleeping, sleep_req;
    pbsp_ctrl_t ctrl;
    logic [15:0] addr;
    logic [31:0] host_data, dq_wire, dq_out;
    int fail_count, check_count, cycles;
    pbsp_port u_pbsp_port (.core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
        .ctrl(ctrl), .addr(addr), .dq_in(dq_wire), .dq_out(dq_out), .dq_oe(dq_oe),
        .output_enable_n(oe_n), .sleep_request(sleep_req), .burst_order_strap(strap),
        .sleeping(sleeping));
    pbsp_host_model u_pbsp_host_model (.core_clk(core_clk), .dq_out(dq_out),
        .dq_oe(dq_oe), .host_drive(host_drive), .host_data(host_data), .dq_wire(dq_wire));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            fail_count = fail_count + 1;
            final_report;
        end
    end
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic drv(input logic sel, input logic [4:0] cmd, input logic [3:0] lanes,
        input logic [15:0] a, input logic [31:0] d, input logic hd);
        @(posedge core_clk);
        ctrl <= {~sel, sel, ~sel, cmd, lanes};
        addr <= a;
        host_data <= d;
        host_drive <= hd;
    endtask
    task automatic do_reset(input logic s);
        @(posedge core_clk);
        reset_n <= 1'b0;
        strap <= s;
        ctrl <= 12'hbff;
        oe_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
    endtask
    task automatic test_burst(input logic s, input logic [1:0] start);
        logic [1:0] low;
        do_reset(s);
        for (int i = 0; i < 4; i++) begin
            drv(1'b1, CW, 4'hf, {14'h048c, i[1:0]}, {16'hbeef, 14'h048c, i[1:0]}, 1'b1);
        end
        drv(1'b0, CR, 4'hf, 16'h0, 32'h0, 1'b0);
        #1;
        check_bit(dq_oe, 1'b0);
        drv(1'b1, PR, 4'hf, {14'h048c, start}, 32'h0, 1'b0);
        oe_n <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            drv(1'b1, (i < 3) ? STEP : IDLE, 4'hf, 16'h0, 32'h0, 1'b0);
            #1;
            low = s ? (start ^ i[1:0]) : (start + i[1:0]);
            check_word(dq_out, {16'hbeef, 14'h048c, low});
            check_bit(dq_oe, i != 0);
        end
        $display("burst test done, strap %b", s);
    endtask
    task automatic test_lanes;
        do_reset(1'b1);
        drv(1'b1, CW, 4'hf, 16'h0100, 32'haaaaaaaa, 1'b1);
        drv(1'b1, CBW, 4'ha, 16'h0100, 32'h11223344, 1'b1);
        drv(1'b1, BOTH, 4'hf, 16'h0100, 32'h55555555, 1'b1);
        drv(1'b1, IDLE, 4'hf, 16'h0, 32'h0, 1'b0);
        oe_n <= 1'b0;
        drv(1'b1, PR, 4'hf, 16'h0100, 32'h0, 1'b0);
        drv(1'b1, IDLE, 4'hf, 16'h0, 32'h0, 1'b0);
        #1;
        check_bit(dq_oe, 1'b1);
        drv(1'b1, IDLE, 4'hf, 16'h0, 32'h0, 1'b0);
        #1;
        check_word(dq_out, 32'haa22aa44);
        $display("lane test done");
    endtask
    task automatic test_sleep;
        do_reset(1'b0);
        drv(1'b1, CW, 4'hf, 16'h0200, 32'h5a5a0f0f, 1'b1);
        drv(1'b0, PR, 4'hf, 16'h0300, 32'h0, 1'b0);
        #1;
        check_bit(sleeping, 1'b0);
        drv(1'b0, IDLE, 4'hf, 16'h0, 32'h0, 1'b0);
        sleep_req <= 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        check_bit(sleeping, 1'b1);
        @(posedge core_clk);
        sleep_req <= 1'b0;
        repeat (6) @(posedge core_clk);
        #1;
        check_bit(sleeping, 1'b0);
        drv(1'b1, PR, 4'hf, 16'h0200, 32'h0, 1'b0);
        oe_n <= 1'b0;
        drv(1'b1, IDLE, 4'hf, 16'h0, 32'h0, 1'b0);
        #1;
        check_word(dq_out, 32'h5a5a0f0f);
        check_bit(dq_oe, 1'b1);
        @(posedge core_clk);
        oe_n <= 1'b1;
        #1;
        check_bit(dq_oe, 1'b0);
        $display("sleep test done");
    endtask
    task automatic final_report;
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        fail_count = 0;
        check_count = 0;
        cycles = 0;
        reset_n = 1'b0;
        oe_n = 1'b1;
        strap = 1'b1;
        host_drive = 1'b0;
        sleep_req = 1'b0;
        ctrl = 12'hbff;
        addr = 16'h0;
        host_data = 32'h0;
        test_burst(1'b1, 2'h1);
        test_burst(1'b0, 2'h2);
        test_lanes;
        test_sleep;
        final_report;
    end
endmodule // test_pipelined_burst_sram_port
`default_nettype wire
